// ===== logic/sef_defs.vh
`ifndef SEF_DEFS_VH
`define SEF_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SEF_ADDR_FLAGS       8'h01
`define SEF_ADDR_AP_FIRST_F0 8'h15
`define SEF_ADDR_AP_LAST_F0  8'h16
`define SEF_ADDR_AP_FIRST_F1 8'h17
`define SEF_ADDR_AP_LAST_F1  8'h18
`define SEF_ADDR_WF_FIRST_F0 8'h19
`define SEF_ADDR_WF_LAST_F0  8'h1A
`define SEF_ADDR_MASK        8'h25

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define SEF_FLAG_W           7
`define SEF_LINE_W           11
`define SEF_BIT_END_REF      0
`define SEF_BIT_START_REF    1
`define SEF_BIT_ANC_CSUM     2
`define SEF_BIT_LOCK         3
`define SEF_BIT_PICTURE_CRC  4
`define SEF_BIT_WHOLE_CRC    5
`define SEF_BIT_STD_MISMATCH 6
`define SEF_FLAGS_RST        7'h00
`define SEF_MASK_RST         7'h00
`define SEF_LINE_RST         11'h000
`define SEF_RDATA_RST        16'h0000

// ----------------------------------------------------------------
// Data mode codes
// ----------------------------------------------------------------
`define SEF_MODE_SMPTE       2'h0
`define SEF_MODE_ASI         2'h1
`define SEF_MODE_THROUGH     2'h2

// ----------------------------------------------------------------
// EDH CRC
// ----------------------------------------------------------------
`define SEF_CRC_SEED         16'h0000
`define SEF_CRC_POLY         16'h1021

// ----------------------------------------------------------------
// Standard calculation lines (first, last) per field
// ----------------------------------------------------------------
`define SEF_525_AP_F0_FIRST  11'h015
`define SEF_525_AP_F0_LAST   11'h106
`define SEF_525_AP_F1_FIRST  11'h11C
`define SEF_525_AP_F1_LAST   11'h20C
`define SEF_525_WF_F0_FIRST  11'h00C
`define SEF_525_WF_F0_LAST   11'h107
`define SEF_525_WF_F1_FIRST  11'h113
`define SEF_525_WF_F1_LAST   11'h20D
`define SEF_625_AP_F0_FIRST  11'h018
`define SEF_625_AP_F0_LAST   11'h136
`define SEF_625_AP_F1_FIRST  11'h151
`define SEF_625_AP_F1_LAST   11'h26E
`define SEF_625_WF_F0_FIRST  11'h007
`define SEF_625_WF_F0_LAST   11'h137
`define SEF_625_WF_F1_FIRST  11'h140
`define SEF_625_WF_F1_LAST   11'h270

`endif

// ===== logic/sef_error_flags.v
// Operation
// - Detection runs only in SMPTE mode; lock loss is watched in every mode.
// - Fault status register at 01h holds one flag per error type.
// - Non-lock flags clear at each field start or on host read.
// - Non-lock flags also clear on standard change, lock loss, manual bypass.
// - Reset forces the whole status register, lock flag included, to zero.
// - Mask register at 25h; a set bit disables that error type.
// - All mask bits are zero after reset.
// - Fault pin is the inverted OR of the flags, idling high.
// - Bit 3 high while lock is low; bits 15-7 read zero.
// - Bit 2 flags an ancillary packet checksum error.
// - Bit 1 flags start reference errors, bit 0 end reference errors.
// - Bit 6 flags payload identifier disagreeing with calculated standard.
// - Whole-field and picture EDH CRCs are computed and compared.
// - Bit 5 whole-field mismatch, bit 4 picture mismatch, shared by fields.
// - CRC mismatches are reported only for correctly received EDH packets.
// - 525 and 625 formats use the standard calculation lines.
// - Other formats use programmed lines (field 1 whole-field follows flywheel), else flywheel timing.
// - Any zero range register selects flywheel timing.
// - Pixel range starts after the start word, ends before the end words.
// - Six writable 11-bit line range registers, reset to zero.
// - Lock indication counts as valid only when high.
// - Timing-based reference errors only with flywheel enable high.
`timescale 1ns/100ps
`include "sef_defs.vh"

module sef_error_flags
(
    input  wire        clk,                       // 125 MHz clock
    input  wire        rst,                       // Synchronous reset, active high
    input  wire [7:0]  reg_addr,                  // Register address
    input  wire [15:0] reg_wdata,                 // Register write data
    input  wire        reg_wr,                    // Write strobe
    input  wire        reg_rd,                    // Read strobe
    output reg  [15:0] reg_rdata,                 // Read data, cycle after strobe
    input  wire [1:0]  data_mode,                 // 0 SMPTE, 1 ASI, 2 pass-through
    input  wire        locked,                    // Lock indication, high = locked
    input  wire        manual_mode,               // Mode selection is manual
    input  wire        video_processing_bypass_n, // Bypass, active low
    input  wire        flywheel_enable,           // Flywheel enable
    input  wire        field_start,               // Pulse at start of each field
    input  wire        std_change,                // Pulse on video standard change
    input  wire        start_ref_hamming_err,     // Pulse, start word code error
    input  wire        start_ref_timing_err,      // Pulse, start word timing error
    input  wire        end_ref_hamming_err,       // Pulse, end word code error
    input  wire        end_ref_timing_err,        // Pulse, end word timing error
    input  wire        anc_csum_err,              // Pulse, ancillary checksum error
    input  wire        payload_id_valid,          // Pulse, payload identifier received
    input  wire [7:0]  payload_id_std,            // Standard in payload identifier
    input  wire [7:0]  calc_std,                  // Standard calculated locally
    input  wire [9:0]  video_data,                // Received video word
    input  wire        video_valid,               // Video word strobe
    input  wire        start_ref_seen,            // Pulse on last start reference word
    input  wire        end_ref_seen,              // Pulse on first end reference word
    input  wire        field_id,                  // Current field, 0 or 1
    input  wire [10:0] line_num,                  // Current line number
    input  wire        fmt_525,                   // Flywheel sees 525-line format
    input  wire        fmt_625,                   // Flywheel sees 625-line format
    input  wire        fw_picture_line,           // Flywheel: line in picture range
    input  wire        fw_whole_line,             // Flywheel: line in whole-field range
    input  wire        edh_rx_ok,                 // Pulse, EDH packet received correctly
    input  wire        edh_picture_valid,         // Received picture CRC is valid
    input  wire        edh_whole_valid,           // Received whole-field CRC is valid
    input  wire [15:0] edh_picture_crc,           // Received picture CRC
    input  wire [15:0] edh_whole_crc,             // Received whole-field CRC
    output reg         data_error_n               // Fault pin, low on any flag
);

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
    function [15:0] crc_step;
        input [15:0] crc;
        input [9:0]  word;
        integer      i;
        reg   [15:0] c;
        begin
            c = crc;
            for (i = 9; i >= 0; i = i - 1)
            begin
                if (c[15] ^ word[i])
                    c = {c[14:0], 1'b0} ^ `SEF_CRC_POLY;
                else
                    c = {c[14:0], 1'b0};
            end
            crc_step = c;
        end
    endfunction

    function line_in;
        input [10:0] line;
        input [10:0] first;
        input [10:0] last;
        begin
            line_in = (line >= first) && (line <= last);
        end
    endfunction

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
    reg  [6:0]  flags_r;
    reg  [6:0]  flags_nxt;
    reg  [6:0]  mask_r;
    reg  [10:0] ap_first_line_field0_r;
    reg  [10:0] ap_last_line_field0_r;
    reg  [10:0] ap_first_line_field1_r;
    reg  [10:0] ap_last_line_field1_r;
    reg  [10:0] whole_field_first_line_field0_r;
    reg  [10:0] whole_field_last_line_field0_r;
    reg  [15:0] rdata_nxt;
    reg         pixel_win_r;
    reg  [15:0] picture_crc_r;
    reg  [15:0] whole_crc_r;
    reg  [15:0] picture_held_r;
    reg  [15:0] whole_held_r;

    wire        smpte_on;
    wire        flags_rd;
    wire        clear_fld;
    wire        prog_ok;
    wire [6:0]  event_raw;
    wire [6:0]  event_det;
    wire        start_ref_err;
    wire        end_ref_err;
    wire        picture_mis;
    wire        whole_mis;
    wire        pixel_take;
    reg         picture_line;
    reg         whole_line;

    assign smpte_on = (data_mode == `SEF_MODE_SMPTE);
    assign flags_rd = reg_rd && (reg_addr == `SEF_ADDR_FLAGS);

// ----------------------------------------------------------------
// Register write port
// ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rst)
        begin
            mask_r                          <= `SEF_MASK_RST;
            ap_first_line_field0_r          <= `SEF_LINE_RST;
            ap_last_line_field0_r           <= `SEF_LINE_RST;
            ap_first_line_field1_r          <= `SEF_LINE_RST;
            ap_last_line_field1_r           <= `SEF_LINE_RST;
            whole_field_first_line_field0_r <= `SEF_LINE_RST;
            whole_field_last_line_field0_r  <= `SEF_LINE_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `SEF_ADDR_MASK:        mask_r <= reg_wdata[6:0];
                `SEF_ADDR_AP_FIRST_F0: ap_first_line_field0_r <= reg_wdata[10:0];
                `SEF_ADDR_AP_LAST_F0:  ap_last_line_field0_r <= reg_wdata[10:0];
                `SEF_ADDR_AP_FIRST_F1: ap_first_line_field1_r <= reg_wdata[10:0];
                `SEF_ADDR_AP_LAST_F1:  ap_last_line_field1_r <= reg_wdata[10:0];
                `SEF_ADDR_WF_FIRST_F0: whole_field_first_line_field0_r <= reg_wdata[10:0];
                `SEF_ADDR_WF_LAST_F0:  whole_field_last_line_field0_r <= reg_wdata[10:0];
                default:               mask_r <= mask_r;
            endcase
        end
    end

// ----------------------------------------------------------------
// Register read port
// ----------------------------------------------------------------
    always @*
    begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            `SEF_ADDR_FLAGS:       rdata_nxt = {9'h000, flags_r};
            `SEF_ADDR_MASK:        rdata_nxt = {9'h000, mask_r};
            `SEF_ADDR_AP_FIRST_F0: rdata_nxt = {5'h00, ap_first_line_field0_r};
            `SEF_ADDR_AP_LAST_F0:  rdata_nxt = {5'h00, ap_last_line_field0_r};
            `SEF_ADDR_AP_FIRST_F1: rdata_nxt = {5'h00, ap_first_line_field1_r};
            `SEF_ADDR_AP_LAST_F1:  rdata_nxt = {5'h00, ap_last_line_field1_r};
            `SEF_ADDR_WF_FIRST_F0: rdata_nxt = {5'h00, whole_field_first_line_field0_r};
            `SEF_ADDR_WF_LAST_F0:  rdata_nxt = {5'h00, whole_field_last_line_field0_r};
            default:               rdata_nxt = 16'h0000;
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge clk)
    begin
        if (rst)
            reg_rdata <= `SEF_RDATA_RST;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= `SEF_RDATA_RST;
    end

// ----------------------------------------------------------------
// Calculation line ranges
// ----------------------------------------------------------------
    assign prog_ok = (ap_first_line_field0_r != 11'h000)
                  && (ap_last_line_field0_r != 11'h000)
                  && (ap_first_line_field1_r != 11'h000)
                  && (ap_last_line_field1_r != 11'h000)
                  && (whole_field_first_line_field0_r != 11'h000)
                  && (whole_field_last_line_field0_r != 11'h000);

    always @*
    begin
        picture_line = fw_picture_line;
        whole_line   = fw_whole_line;
        if (fmt_525)
        begin
            if (field_id)
            begin
                picture_line = line_in(line_num, `SEF_525_AP_F1_FIRST, `SEF_525_AP_F1_LAST);
                whole_line   = line_in(line_num, `SEF_525_WF_F1_FIRST, `SEF_525_WF_F1_LAST);
            end
            else
            begin
                picture_line = line_in(line_num, `SEF_525_AP_F0_FIRST, `SEF_525_AP_F0_LAST);
                whole_line   = line_in(line_num, `SEF_525_WF_F0_FIRST, `SEF_525_WF_F0_LAST);
            end
        end
        else if (fmt_625)
        begin
            if (field_id)
            begin
                picture_line = line_in(line_num, `SEF_625_AP_F1_FIRST, `SEF_625_AP_F1_LAST);
                whole_line   = line_in(line_num, `SEF_625_WF_F1_FIRST, `SEF_625_WF_F1_LAST);
            end
            else
            begin
                picture_line = line_in(line_num, `SEF_625_AP_F0_FIRST, `SEF_625_AP_F0_LAST);
                whole_line   = line_in(line_num, `SEF_625_WF_F0_FIRST, `SEF_625_WF_F0_LAST);
            end
        end
        else if (prog_ok)
        begin
            if (field_id)
            begin
                picture_line = line_in(line_num, ap_first_line_field1_r,
                                       ap_last_line_field1_r);
                // Field 1 whole-field lines follow the flywheel
                whole_line   = fw_whole_line;
            end
            else
            begin
                picture_line = line_in(line_num, ap_first_line_field0_r,
                                       ap_last_line_field0_r);
                whole_line   = line_in(line_num, whole_field_first_line_field0_r,
                                       whole_field_last_line_field0_r);
            end
        end
    end

// ----------------------------------------------------------------
// Pixel window and CRC accumulation
// ----------------------------------------------------------------
    // Open after the start reference, closed at the first end word
    always @(posedge clk)
    begin
        if (rst)
            pixel_win_r <= 1'b0;
        else if (end_ref_seen)
            pixel_win_r <= 1'b0;
        else if (start_ref_seen)
            pixel_win_r <= 1'b1;
    end

    assign pixel_take = video_valid && pixel_win_r && !end_ref_seen && smpte_on;

    always @(posedge clk)
    begin
        if (rst)
        begin
            picture_crc_r  <= `SEF_CRC_SEED;
            whole_crc_r    <= `SEF_CRC_SEED;
            picture_held_r <= `SEF_CRC_SEED;
            whole_held_r   <= `SEF_CRC_SEED;
        end
        else if (field_start)
        begin
            // Finished field result waits for its EDH packet
            picture_held_r <= picture_crc_r;
            whole_held_r   <= whole_crc_r;
            picture_crc_r  <= `SEF_CRC_SEED;
            whole_crc_r    <= `SEF_CRC_SEED;
        end
        else if (pixel_take)
        begin
            if (picture_line)
                picture_crc_r <= crc_step(picture_crc_r, video_data);
            if (whole_line)
                whole_crc_r <= crc_step(whole_crc_r, video_data);
        end
    end

    assign picture_mis = edh_rx_ok && edh_picture_valid
                      && (edh_picture_crc != picture_held_r);
    assign whole_mis   = edh_rx_ok && edh_whole_valid
                      && (edh_whole_crc != whole_held_r);

// ----------------------------------------------------------------
// Error events
// ----------------------------------------------------------------
    assign start_ref_err = start_ref_hamming_err
                        || (start_ref_timing_err && flywheel_enable);
    assign end_ref_err   = end_ref_hamming_err
                        || (end_ref_timing_err && flywheel_enable);

    assign event_raw[`SEF_BIT_END_REF]      = end_ref_err;
    assign event_raw[`SEF_BIT_START_REF]    = start_ref_err;
    assign event_raw[`SEF_BIT_ANC_CSUM]     = anc_csum_err;
    assign event_raw[`SEF_BIT_LOCK]         = !locked;
    assign event_raw[`SEF_BIT_PICTURE_CRC]  = picture_mis;
    assign event_raw[`SEF_BIT_WHOLE_CRC]    = whole_mis;
    assign event_raw[`SEF_BIT_STD_MISMATCH] = payload_id_valid
                                           && (payload_id_std != calc_std);

    // Mode gate and mask gate for each flag except lock, which has the mask gate only
    genvar g;
    generate
        for (g = 0; g < `SEF_FLAG_W; g = g + 1)
        begin : gate_gen
            if (g == `SEF_BIT_LOCK)
            begin : lock_gen
                assign event_det[g] = event_raw[g] && !mask_r[g];
            end
            else
            begin : smpte_gen
                assign event_det[g] = event_raw[g] && smpte_on && !mask_r[g];
            end
        end
    endgenerate

// ----------------------------------------------------------------
// Fault status flags
// ----------------------------------------------------------------
    assign clear_fld = field_start || flags_rd
                    || std_change || !locked
                    || (manual_mode && !video_processing_bypass_n);

    always @*
    begin
        flags_nxt = flags_r;
        if (clear_fld)
            flags_nxt = flags_r & (7'h01 << `SEF_BIT_LOCK);
        // Lock flag tracks the lock indication
        flags_nxt[`SEF_BIT_LOCK] = event_det[`SEF_BIT_LOCK];
        // New events win over any clear
        flags_nxt = flags_nxt | event_det;
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            flags_r      <= `SEF_FLAGS_RST;
            data_error_n <= 1'b1;
        end
        else
        begin
            flags_r      <= flags_nxt;
            data_error_n <= ~(|flags_nxt);
        end
    end

endmodule // sef_error_flags

// ===== dv/sef_error_flags_props.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module sef_error_flags_chk
(
    input wire        clk,                   // Clock
    input wire        rst,                   // Reset
    input wire [7:0]  reg_addr,              // Address
    input wire [15:0] reg_wdata,             // Write data
    input wire        reg_wr,                // Write strobe
    input wire        reg_rd,                // Read strobe
    input wire [15:0] reg_rdata,             // Read data
    input wire [1:0]  data_mode,             // Mode
    input wire        locked,                // Lock
    input wire        flywheel_enable,       // Flywheel
    input wire        field_start,           // Field start
    input wire        std_change,            // Standard change
    input wire        start_ref_hamming_err, // Event
    input wire        start_ref_timing_err,  // Event
    input wire        end_ref_hamming_err,   // Event
    input wire        end_ref_timing_err,    // Event
    input wire        anc_csum_err,          // Event
    input wire        payload_id_valid,      // Event
    input wire [7:0]  payload_id_std,        // Received standard
    input wire [7:0]  calc_std,              // Local standard
    input wire        edh_rx_ok,             // Event
    input wire        data_error_n           // Fault pin
);
    reg  [6:0] mask_r;
    wire       smpte = data_mode == 2'h0;
    wire       evq = !(start_ref_hamming_err | start_ref_timing_err | end_ref_hamming_err |
                       end_ref_timing_err | anc_csum_err | payload_id_valid | edh_rx_ok);
    wire       cause = !locked || !evq;

    // Shadow of the mask register
    always @(posedge clk)
        if (rst)
            mask_r <= 7'h00;
        else if (reg_wr && reg_addr == 8'h25)
            mask_r <= reg_wdata[6:0];

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    reset_clear_a: assert property (disable iff (1'b0)
        rst |=> data_error_n && reg_rdata == 16'h0000)
        else $error("reset left fault or data");
    lock_flag_a: assert property (!locked && !mask_r[3] |=> !data_error_n)
        else $error("lock loss not shown");
    csum_set_a: assert property (smpte && anc_csum_err && !mask_r[2] |=> !data_error_n)
        else $error("checksum error not shown");
    start_ref_a: assert property (smpte && start_ref_hamming_err && !mask_r[1]
        |=> !data_error_n)
        else $error("start reference error not shown");
    timing_ref_a: assert property (smpte && flywheel_enable && end_ref_timing_err
        && !mask_r[0] |=> !data_error_n)
        else $error("timing error not shown");
    std_flag_a: assert property (smpte && payload_id_valid && payload_id_std != calc_std
        && !mask_r[6] |=> !data_error_n)
        else $error("standard mismatch not shown");
    fault_cause_a: assert property ($fell(data_error_n) |-> $past(cause))
        else $error("fault pin fell without cause");
    flag_clear_a: assert property (locked && evq && (field_start || std_change ||
        reg_rd && reg_addr == 8'h01) |=> data_error_n)
        else $error("flags not cleared");

    cover property (reg_rd && reg_addr == 8'h01);
    cover property ($fell(data_error_n));
    cover property (field_start && !data_error_n);
endmodule // sef_error_flags_chk

// ===== dv/sef_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host processor on the register port
// ----------------------------------------------------------------
module sef_host_model
(
    input  wire         clk,       // Clock
    input  wire  [15:0] reg_rdata, // Read data
    output logic [7:0]  reg_addr,  // Address
    output logic [15:0] reg_wdata, // Write data
    output logic        reg_wr,    // Write strobe
    output logic        reg_rd     // Read strobe
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 26'h0;

    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule // sef_host_model

// ===== dv/sef_error_flags_tb.sv
`timescale 1ns/100ps
module sef_error_flags_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  data_mode = 2'h0;
    logic        locked = 1'b1;
    logic        manual_mode = 1'b0;
    logic        video_processing_bypass_n = 1'b1;
    logic        flywheel_enable = 1'b1;
    logic [8:0]  ev = 9'h000;
    logic [7:0]  payload_id_std = 8'h01;
    logic [7:0]  calc_std = 8'h02;
    logic [9:0]  video_data = 10'h000;
    logic        video_valid = 1'b0;
    logic        start_ref_seen = 1'b0;
    logic        end_ref_seen = 1'b0;
    logic        field_id = 1'b0;
    logic [10:0] line_num = 11'h000;
    logic        fmt_525 = 1'b0;
    logic        fmt_625 = 1'b0;
    logic        fw_picture_line = 1'b0;
    logic        fw_whole_line = 1'b0;
    logic        edh_picture_valid = 1'b1;
    logic        edh_whole_valid = 1'b1;
    logic [15:0] edh_picture_crc = 16'h0000;
    logic [15:0] edh_whole_crc = 16'h0000;
    wire         edh_rx_ok, start_ref_timing_err, end_ref_timing_err, std_change, field_start;
    wire         payload_id_valid, anc_csum_err, start_ref_hamming_err, end_ref_hamming_err;
    wire [7:0]   reg_addr;
    wire [15:0]  reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd, data_error_n;
    int          fail_count = 0;
    int          checked = 0;

    assign {edh_rx_ok, start_ref_timing_err, end_ref_timing_err, std_change, field_start,
            payload_id_valid, anc_csum_err, start_ref_hamming_err, end_ref_hamming_err} = ev;

    sef_error_flags dut_u (.*);
    sef_host_model  host_u (.*);

    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task rchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host_u.rd(a, d);
        chk(d, e);
    endtask

    task pulse(input logic [8:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 9'h000;
        @(negedge clk);
    endtask

    task set_lock(input logic v);
        @(posedge clk);
        locked <= v;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task results;
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        chk(16'(data_error_n), 16'h0001);
        rchk(8'h01, 16'h0000);
        rchk(8'h25, 16'h0000);
    endtask

    task t_flags;
        for (int i = 0; i < 4; i++)
        begin
            pulse(9'h001 << i);
            chk(16'(data_error_n), 16'h0000);
            rchk(8'h01, i == 3 ? 16'h0040 : 16'h0001 << i);
            rchk(8'h01, 16'h0000);
        end
    endtask

    task t_clears;
        pulse(9'h004);
        pulse(9'h010);
        rchk(8'h01, 16'h0000);
        pulse(9'h004);
        pulse(9'h020);
        rchk(8'h01, 16'h0000);
        pulse(9'h004);
        @(posedge clk);
        manual_mode <= 1'b1;
        video_processing_bypass_n <= 1'b0;
        @(posedge clk);
        video_processing_bypass_n <= 1'b1;
        rchk(8'h01, 16'h0000);
        pulse(9'h014);
        rchk(8'h01, 16'h0004);
        pulse(9'h004);
        set_lock(1'b0);
        rchk(8'h01, 16'h0008);
        set_lock(1'b1);
        rchk(8'h01, 16'h0000);
    endtask

    task t_mode_fly;
        @(posedge clk);
        data_mode <= 2'h1;
        pulse(9'h0CF);
        set_lock(1'b0);
        rchk(8'h01, 16'h0008);
        set_lock(1'b1);
        @(posedge clk);
        data_mode <= 2'h0;
        flywheel_enable <= 1'b0;
        pulse(9'h0C0);
        rchk(8'h01, 16'h0000);
        @(posedge clk);
        flywheel_enable <= 1'b1;
        pulse(9'h0C0);
        rchk(8'h01, 16'h0003);
    endtask

    task t_mask;
        host_u.wr(8'h25, 16'hFFFF);
        rchk(8'h25, 16'h007F);
        pulse(9'h0CF);
        set_lock(1'b0);
        chk(16'(data_error_n), 16'h0001);
        rchk(8'h01, 16'h0000);
        set_lock(1'b1);
        host_u.wr(8'h25, 16'h0000);
        host_u.wr(8'h01, 16'hFFFF);
        rchk(8'h01, 16'h0000);
        rchk(8'h30, 16'h0000);
    endtask

    task t_edh;
        for (int a = 8'h15; a <= 8'h1A; a++)
            host_u.wr(8'(a), 16'hF800 | 16'(a));
        for (int a = 8'h15; a <= 8'h1A; a++)
            rchk(8'(a), 16'(a));
        pulse(9'h010);
        @(posedge clk);
        edh_picture_crc <= 16'h0001;
        pulse(9'h100);
        rchk(8'h01, 16'h0010);
        @(posedge clk);
        edh_picture_crc <= 16'h0000;
        edh_whole_crc <= 16'h0005;
        pulse(9'h100);
        rchk(8'h01, 16'h0020);
        @(posedge clk);
        line_num <= 11'h015;
        fmt_525 <= 1'b1;
        start_ref_seen <= 1'b1;
        @(posedge clk);
        start_ref_seen <= 1'b0;
        video_valid <= 1'b1;
        video_data <= 10'h200;
        @(posedge clk);
        video_valid <= 1'b0;
        pulse(9'h010);
        @(posedge clk);
        edh_picture_crc <= 16'h6662;
        edh_whole_crc <= 16'h6662;
        pulse(9'h100);
        rchk(8'h01, 16'h0000);
    endtask

    initial
    begin
        #200000;
        fail_count++;
        results;
    end

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset;
        t_flags;
        t_clears;
        t_mode_fly;
        t_mask;
        t_edh;
        results;
    end
endmodule // sef_error_flags_tb

bind sef_error_flags sef_error_flags_chk chk_u (.*);
